// ---- hw/tlbx_params.svh ----
// buffer constants: geometry, keys, registers, timing
// assumes includers need only defines
`ifndef TLBX_PARAMS_SVH
`define TLBX_PARAMS_SVH
`define TLBX_ROWS 32
`define TLBX_ROW_W 5
`define TLBX_TAG_W 8
`define TLBX_REAL_W 13
`define TLBX_OFS_W 19
`define TLBX_KEY_W 7
`define TLBX_BLK_LSB 11
`define TLBX_NUM_BLOCKS 64
// key fields: access [6:3], fetch protect [2], reference [1], change [0]
`define TLBX_KEY_REF 1
`define TLBX_KEY_CHG 0
// register byte offsets
`define TLBX_REG_CTRL 5'h00
`define TLBX_REG_KADDR 5'h04
`define TLBX_REG_KDATA 5'h08
`define TLBX_REG_STAT 5'h0C
`define TLBX_REG_LIMIT 5'h10
`define TLBX_REG_PGSZ 5'h14
// control bits
`define TLBX_CTL_PURGE 0
`define TLBX_CTL_CLRREF 1
`define TLBX_CTL_SETKEY 2
`define TLBX_CTL_RDKEY 3
// reset values
`define TLBX_LIMIT_RST 32'hFFFFFFFF
`define TLBX_PGSZ_RST 1'b0
// untranslated miss penalty, ns and clock period in ns
`define TLBX_MISS_NS 1430
`define TLBX_CLK_NS 4
`define TLBX_MISS_CYC ((`TLBX_MISS_NS + `TLBX_CLK_NS - 1) / `TLBX_CLK_NS)
`endif

// ---- hw/tlbx_pkg.sv ----
// types of the buffer and key store
// assumes tlbx_params.svh supplies the widths
`include "tlbx_params.svh"
package tlbx_pkg;
	typedef enum logic [2:0]
	{
		TLBX_ST_IDLE = 3'b000,
		TLBX_ST_LOOK = 3'b001,
		TLBX_ST_WALK = 3'b010,
		TLBX_ST_DELAY = 3'b011,
		TLBX_ST_KRD = 3'b100,
		TLBX_ST_KMOD = 3'b101
	} tlbx_state_t;
	typedef enum logic [1:0]
	{
		TLBX_KIND_CPU = 2'b00,
		TLBX_KIND_NOXLT = 2'b01,
		TLBX_KIND_CHAN = 2'b10
	} tlbx_kind_t;
	typedef enum logic [1:0]
	{
		TLBX_OP_ACC = 2'b00,
		TLBX_OP_CLR = 2'b01,
		TLBX_OP_SET = 2'b10,
		TLBX_OP_RD = 2'b11
	} tlbx_op_t;
	typedef struct packed
	{
		logic valid;
		logic is_real;
		logic lim_chk;
		logic [`TLBX_TAG_W-1:0] tag;
		logic [`TLBX_REAL_W-1:0] real_hi;
	} tlbx_entry_t;
endpackage

// ---- hw/tlbx_key_if.sv ----
// port bundle between the buffer and its storage-key memory
// assumes one writer and registered read data
`timescale 1ns/1ps
interface tlbx_key_if #(parameter int AW = 6);
	logic [AW-1:0] addr; // block index
	logic we; // write strobe
	logic [`TLBX_KEY_W-1:0] wdata;
	logic [`TLBX_KEY_W-1:0] rdata; // key array copy
	logic [`TLBX_KEY_W-1:0] rcopy; // translation table copy
	modport ctl (output addr, output we, output wdata, input rdata, input rcopy);
	modport mem (input addr, input we, input wdata, output rdata, output rcopy);
endinterface

// ---- hw/tlbx_key_mem.sv ----
// storage-key memory: key array plus table copy
// assumes no reset; read data one cycle after address
`timescale 1ns/1ps
module tlbx_key_mem
	import tlbx_pkg::*;
#(
	parameter int NUM_BLOCKS = `TLBX_NUM_BLOCKS,
	parameter int AW = 6
)
(
	input wire logic i_ref_clk,
	tlbx_key_if.mem kif
);
	// written together so the copy never drifts
	logic [`TLBX_KEY_W-1:0] key_mem [NUM_BLOCKS];
	logic [`TLBX_KEY_W-1:0] copy_mem [NUM_BLOCKS];
	logic [`TLBX_KEY_W-1:0] rd_q;
	logic [`TLBX_KEY_W-1:0] cp_q;

	// write both copies, read out through registers
	always_ff @(posedge i_ref_clk)
	begin
		if (kif.we)
		begin
			key_mem[kif.addr] <= kif.wdata;
			copy_mem[kif.addr] <= kif.wdata;
		end
		rd_q <= key_mem[kif.addr];
		cp_q <= copy_mem[kif.addr];
	end
	assign kif.rdata = rd_q;
	assign kif.rcopy = cp_q;
endmodule

// ---- hw/tlbx_top.sv ----
// Function
// - row index from address bits 8 to 12
// - compare both columns of row together
// - virtual valid unchecked match hits, joins offset
// - any hit updates row replacement bit
// - hit delivers real address without walk
// - invalid matching entry ignored, walk instead
// - limit-check match raises addressing exception
// - translated miss walks, fills replacement column
// - untranslated miss fills real address twice
// - untranslated miss adds 1.43 us
// - page size change invalidates all entries
// - purge command invalidates all entries
// - buffer is always in use
// - error retries or reports processing damage
// - key, shift, channel addresses bypass translation
// - seven-bit key per 2K block
// - fetch sets block reference bit
// - store sets change and reference bits
// - clear-reference zeroes only reference bit
// - recording always active, no switch
// - page fault nullifies, no state altered
// - keys kept in array plus table copy
// - load or use points replacement at other column
// - reset clears valid, replacement to left
// - key write invalidates virtual and matching real
// - virtual load sets limit check at/above limit
//
// buffer top: lookup, walk, key store, Avalon-MM slave
// assumes synchronous inputs; i_req_valid held until o_req_done
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module tlbx_top
	import tlbx_pkg::*;
#(
	parameter int NUM_BLOCKS = `TLBX_NUM_BLOCKS,
	parameter int MISS_CYC = `TLBX_MISS_CYC
)
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_req_valid,
	input wire logic [31:0] i_req_addr,
	input wire logic [1:0] i_req_kind,
	input wire logic i_req_store,
	input wire logic i_address_mapping_enable,
	output logic o_req_done,
	output logic o_req_hit,
	output logic [31:0] o_real_addr,
	output logic o_addr_exc,
	output logic o_nullify,
	output logic o_walk_req,
	output logic [31:0] o_walk_vaddr,
	input wire logic i_walk_done,
	input wire logic i_walk_fault,
	input wire logic [31:0] i_walk_real,
	input wire logic i_buf_err,
	input wire logic i_retryable,
	output logic o_retry,
	output logic o_proc_damage
);
	localparam int KAW = $clog2(NUM_BLOCKS);
	localparam int CW = 9;

	// refuse geometries the key index and penalty counter cannot serve
	initial
	begin
		if (NUM_BLOCKS < 2 || (1 << KAW) != NUM_BLOCKS || KAW > 32 - `TLBX_BLK_LSB)
			$error("tlbx_top: NUM_BLOCKS must be a power of two that fits the address");
		if (MISS_CYC < 1 || MISS_CYC >= (1 << CW))
			$error("tlbx_top: MISS_CYC out of counter range");
	end

	typedef struct packed
	{
		tlbx_state_t st; // sequencer state
		tlbx_op_t op; // what the key step does
		logic pend; // bus command waiting
		logic mapped; // lookup is translated
		logic store; // access is a store
		logic [31:0] vaddr; // latched request address
		logic [CW-1:0] cnt; // untranslated miss penalty
		logic [KAW-1:0] kaddr; // key memory index
		logic kwe;
		logic [`TLBX_KEY_W-1:0] kwd;
		tlbx_entry_t [2*`TLBX_ROWS-1:0] ent; // index {column,row}
		logic [`TLBX_ROWS-1:0] lru; // 0 = left column next
		logic [31:0] limit; // storage limit register
		logic pgsz; // page size in effect
		logic [31:0] kreg_addr;
		logic [`TLBX_KEY_W-1:0] kreg_data;
		logic [`TLBX_KEY_W-1:0] key_rd;
		logic last_hit;
		logic done;
		logic hit;
		logic [31:0] real_addr;
		logic exc;
		logic nullify;
		logic walk;
		logic retry;
		logic dmg;
		logic wait_n; // waitrequest, idle high
		logic [31:0] rdata;
	} tlbx_state_s_t;

	// every valid bit clear, every row pointing left, waitrequest high
	localparam tlbx_state_s_t RST = '{st: TLBX_ST_IDLE, op: TLBX_OP_ACC,
		limit: `TLBX_LIMIT_RST, pgsz: `TLBX_PGSZ_RST, wait_n: 1'b1, default: '0};

	tlbx_state_s_t s_q;
	tlbx_state_s_t s_d;
	logic [1:0] rst_sync_q; // release synchroniser
	logic rst_n;
	tlbx_key_if #(.AW(KAW)) kif ();

	// key memory with its table mirror
	tlbx_key_mem #(.NUM_BLOCKS(NUM_BLOCKS), .AW(KAW)) u_keys
	(
		.i_ref_clk(i_ref_clk),
		.kif(kif)
	);
	assign kif.addr = s_q.kaddr;
	assign kif.we = s_q.kwe;
	assign kif.wdata = s_q.kwd;

	// asynchronous assert, two-flop release
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// row select: address bits 8..12 in big-endian numbering
	function automatic logic [`TLBX_ROW_W-1:0] row_of(input logic [31:0] a);
		row_of = a[23:19];
	endfunction

	// tag: address bits 0..7
	function automatic logic [`TLBX_TAG_W-1:0] tag_of(input logic [31:0] a);
		tag_of = a[31:24];
	endfunction

	// 2K block index of a real address
	function automatic logic [KAW-1:0] blk_of(input logic [31:0] a);
		blk_of = a[`TLBX_BLK_LSB +: KAW];
	endfunction

	// byte-enable merge of a 32-bit register
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		be_merge = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				be_merge[8*i +: 8] = wd[8*i +: 8];
	endfunction

	// tag match on a usable entry of the right kind; limit check judged separately
	function automatic logic usable(input tlbx_entry_t e, input logic [31:0] a,
		input logic mapped);
		usable = e.valid && (e.tag == tag_of(a)) && (e.is_real == !mapped);
	endfunction

	// next state
	always_comb
	begin
		logic [`TLBX_ROW_W-1:0] row;
		logic u0;
		logic u1;
		logic col;
		logic [5:0] idx;
		logic acc;
		logic wr;
		logic [31:0] ra;
		row = row_of(s_q.vaddr);
		u0 = usable(s_q.ent[{1'b0, row}], s_q.vaddr, s_q.mapped);
		u1 = usable(s_q.ent[{1'b1, row}], s_q.vaddr, s_q.mapped);
		col = u1 && !u0;
		idx = {s_q.lru[row], row};
		ra = '0;
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.kwe = 1'b0;
		s_d.retry = 1'b0;
		s_d.dmg = 1'b0;
		s_d.nullify = 1'b0;
		s_d.exc = 1'b0;
		s_d.wait_n = 1'b1;

		// bus slave: one answer per request, then waitrequest returns high
		acc = 1'b0;
		wr = 1'b0;
		if ((i_avs_read || i_avs_write) && s_q.wait_n)
		begin
			// command writes wait while one is still outstanding
			acc = !(i_avs_write && i_avs_address == `TLBX_REG_CTRL && s_q.pend);
			wr = acc && i_avs_write;
		end
		if (acc)
		begin
			s_d.wait_n = 1'b0;
			s_d.rdata = '0;
			case (i_avs_address)
				`TLBX_REG_CTRL: s_d.rdata[0] = s_q.pend;
				`TLBX_REG_KADDR: s_d.rdata = s_q.kreg_addr;
				`TLBX_REG_KDATA: s_d.rdata[`TLBX_KEY_W-1:0] = s_q.key_rd;
				`TLBX_REG_STAT: s_d.rdata[1:0] = {s_q.st != TLBX_ST_IDLE, s_q.last_hit};
				`TLBX_REG_LIMIT: s_d.rdata = s_q.limit;
				`TLBX_REG_PGSZ: s_d.rdata[0] = s_q.pgsz;
				default: s_d.rdata = '0; // unmapped reads as zero
			endcase
		end
		if (wr)
		begin
			case (i_avs_address)
				`TLBX_REG_CTRL:
				begin
					if (i_avs_byteenable[0] && i_avs_writedata[`TLBX_CTL_PURGE])
						for (int i = 0; i < 2*`TLBX_ROWS; i++)
							s_d.ent[i].valid = 1'b0;
					// one key command at a time, lowest bit first
					if (i_avs_byteenable[0] && i_avs_writedata[`TLBX_CTL_CLRREF])
					begin
						s_d.pend = 1'b1;
						s_d.op = TLBX_OP_CLR;
					end
					else if (i_avs_byteenable[0] && i_avs_writedata[`TLBX_CTL_SETKEY])
					begin
						s_d.pend = 1'b1;
						s_d.op = TLBX_OP_SET;
					end
					else if (i_avs_byteenable[0] && i_avs_writedata[`TLBX_CTL_RDKEY])
					begin
						s_d.pend = 1'b1;
						s_d.op = TLBX_OP_RD;
					end
				end
				`TLBX_REG_KADDR: s_d.kreg_addr = be_merge(s_q.kreg_addr, i_avs_writedata,
					i_avs_byteenable);
				`TLBX_REG_KDATA:
					if (i_avs_byteenable[0])
						s_d.kreg_data = i_avs_writedata[`TLBX_KEY_W-1:0];
				`TLBX_REG_LIMIT: s_d.limit = be_merge(s_q.limit, i_avs_writedata,
					i_avs_byteenable);
				`TLBX_REG_PGSZ:
					if (i_avs_byteenable[0])
					begin
						s_d.pgsz = i_avs_writedata[0];
						if (i_avs_writedata[0] != s_q.pgsz)
							for (int i = 0; i < 2*`TLBX_ROWS; i++)
								s_d.ent[i].valid = 1'b0;
					end
				default: ; // unmapped writes are dropped
			endcase
		end

		// sequencer; there is no bypass path, every cpu access goes through the buffer
		case (s_q.st)
			TLBX_ST_IDLE:
			begin
				if (s_q.pend)
				begin
					s_d.kaddr = blk_of(s_q.kreg_addr);
					s_d.st = TLBX_ST_KRD;
				end
				else if (i_req_valid)
				begin
					s_d.vaddr = i_req_addr;
					s_d.store = i_req_store;
					s_d.mapped = i_address_mapping_enable;
					s_d.op = TLBX_OP_ACC;
					if (i_req_kind == TLBX_KIND_NOXLT)
					begin
						// key locations, shift amounts: passed through untranslated
						s_d.real_addr = i_req_addr;
						s_d.hit = 1'b0;
						s_d.done = 1'b1;
					end
					else if (i_req_kind == TLBX_KIND_CHAN)
					begin
						// channel list addresses are real; only recorded
						s_d.real_addr = i_req_addr;
						s_d.hit = 1'b0;
						s_d.kaddr = blk_of(i_req_addr);
						s_d.st = TLBX_ST_KRD;
					end
					else
						s_d.st = TLBX_ST_LOOK;
				end
			end
			TLBX_ST_LOOK:
			begin
				if ((u0 && s_q.ent[{1'b0, row}].lim_chk) || (!u0 && u1 &&
					s_q.ent[{1'b1, row}].lim_chk))
				begin
					// addressing exception ends all translation for this access
					s_d.exc = 1'b1;
					s_d.done = 1'b1;
					s_d.hit = 1'b0;
					s_d.st = TLBX_ST_IDLE;
				end
				else if (u0 || u1)
				begin
					ra = {s_q.ent[{col, row}].real_hi, s_q.vaddr[`TLBX_OFS_W-1:0]};
					s_d.real_addr = ra;
					s_d.hit = 1'b1;
					s_d.last_hit = 1'b1;
					s_d.lru[row] = !col;
					s_d.kaddr = blk_of(ra);
					s_d.st = TLBX_ST_KRD;
				end
				else if (s_q.mapped)
				begin
					s_d.last_hit = 1'b0;
					s_d.walk = 1'b1;
					s_d.st = TLBX_ST_WALK;
				end
				else
				begin
					s_d.last_hit = 1'b0;
					s_d.cnt = CW'(MISS_CYC - 1);
					s_d.st = TLBX_ST_DELAY;
				end
			end
			TLBX_ST_WALK:
			begin
				if (i_walk_fault)
				begin
					// nothing is filled or recorded so the access can be reissued
					s_d.walk = 1'b0;
					s_d.nullify = 1'b1;
					s_d.done = 1'b1;
					s_d.hit = 1'b0;
					s_d.st = TLBX_ST_IDLE;
				end
				else if (i_walk_done)
				begin
					s_d.walk = 1'b0;
					s_d.ent[idx].valid = 1'b1;
					s_d.ent[idx].is_real = 1'b0;
					s_d.ent[idx].tag = tag_of(s_q.vaddr);
					s_d.ent[idx].real_hi = i_walk_real[31:`TLBX_OFS_W];
					s_d.ent[idx].lim_chk = (i_walk_real >= s_q.limit);
					s_d.lru[row] = !s_q.lru[row];
					ra = {i_walk_real[31:`TLBX_OFS_W], s_q.vaddr[`TLBX_OFS_W-1:0]};
					s_d.real_addr = ra;
					s_d.hit = 1'b0;
					if (i_walk_real >= s_q.limit)
					begin
						s_d.exc = 1'b1;
						s_d.done = 1'b1;
						s_d.st = TLBX_ST_IDLE;
					end
					else
					begin
						s_d.kaddr = blk_of(ra);
						s_d.st = TLBX_ST_KRD;
					end
				end
			end
			TLBX_ST_DELAY:
			begin
				if (s_q.cnt != '0)
					s_d.cnt = s_q.cnt - CW'(1);
				else
				begin
					// same real address in tag and real fields
					s_d.ent[idx].valid = 1'b1;
					s_d.ent[idx].is_real = 1'b1;
					s_d.ent[idx].lim_chk = 1'b0;
					s_d.ent[idx].tag = tag_of(s_q.vaddr);
					s_d.ent[idx].real_hi = s_q.vaddr[31:`TLBX_OFS_W];
					s_d.lru[row] = !s_q.lru[row];
					s_d.real_addr = s_q.vaddr;
					s_d.hit = 1'b0;
					s_d.kaddr = blk_of(s_q.vaddr);
					s_d.st = TLBX_ST_KRD;
				end
			end
			TLBX_ST_KRD:
				s_d.st = TLBX_ST_KMOD; // key memory read latency
			TLBX_ST_KMOD:
			begin
				s_d.st = TLBX_ST_IDLE;
				case (s_q.op)
					TLBX_OP_ACC:
					begin
						// recording cannot be switched off
						s_d.kwd = kif.rdata;
						s_d.kwd[`TLBX_KEY_REF] = 1'b1;
						if (s_q.store)
							s_d.kwd[`TLBX_KEY_CHG] = 1'b1;
						s_d.kwe = 1'b1;
						s_d.done = 1'b1;
					end
					TLBX_OP_CLR:
					begin
						s_d.kwd = kif.rdata;
						s_d.kwd[`TLBX_KEY_REF] = 1'b0;
						s_d.kwe = 1'b1;
						s_d.pend = 1'b0;
					end
					TLBX_OP_SET:
					begin
						s_d.kwd = s_q.kreg_data;
						s_d.kwe = 1'b1;
						s_d.pend = 1'b0;
						for (int i = 0; i < 2*`TLBX_ROWS; i++)
							if (!s_q.ent[i].is_real || s_q.ent[i].real_hi ==
								s_q.kreg_addr[31:`TLBX_OFS_W])
								s_d.ent[i].valid = 1'b0;
					end
					default:
					begin
						s_d.key_rd = kif.rcopy;
						s_d.pend = 1'b0;
					end
				endcase
			end
			default: s_d.st = TLBX_ST_IDLE;
		endcase

		// buffer error: drop all contents, then retry or report damage
		if (i_buf_err)
		begin
			for (int i = 0; i < 2*`TLBX_ROWS; i++)
				s_d.ent[i].valid = 1'b0;
			s_d.retry = i_retryable;
			s_d.dmg = !i_retryable;
		end
	end

	// single state register; reset clears every entry and points rows left
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= RST;
		else
			s_q <= s_d;
	end

	assign o_avs_readdata = s_q.rdata;
	assign o_avs_waitrequest = s_q.wait_n;
	assign o_req_done = s_q.done;
	assign o_req_hit = s_q.hit;
	assign o_real_addr = s_q.real_addr;
	assign o_addr_exc = s_q.exc;
	assign o_nullify = s_q.nullify;
	assign o_walk_req = s_q.walk;
	assign o_walk_vaddr = s_q.vaddr;
	assign o_retry = s_q.retry;
	assign o_proc_damage = s_q.dmg;
endmodule

// ---- testbench/tlbx_top_monitor.sv ----
// checker of the buffer top's lookup, walk and error outputs
// assumes it is bound to tlbx_top and sees only the top's own ports
`timescale 1ns/1ps
module tlbx_top_monitor
	import tlbx_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_req_valid,
	input wire logic [31:0] i_req_addr,
	input wire logic [1:0] i_req_kind,
	input wire logic i_walk_fault,
	input wire logic i_buf_err,
	input wire logic i_retryable,
	input wire logic o_req_done,
	input wire logic o_req_hit,
	input wire logic [31:0] o_real_addr,
	input wire logic o_addr_exc,
	input wire logic o_nullify,
	input wire logic o_walk_req,
	input wire logic [31:0] o_walk_vaddr,
	input wire logic o_retry,
	input wire logic o_proc_damage
);
	// one clock domain
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_reset_n);
	// a hit is never preceded by a walk of its own
	property p_hit_nowalk;
		o_req_done && o_req_hit |-> !$past(o_walk_req, 1) && !$past(o_walk_req, 2)
			&& !$past(o_walk_req, 3);
	endproperty
	a_hit_nowalk: assert property (p_hit_nowalk)
		else $error("hit answered after a walk");
	// a hit keeps the low offset of the request
	property p_hit_ofs;
		o_req_done && o_req_hit && i_req_kind == TLBX_KIND_CPU
			|-> o_real_addr[18:0] == i_req_addr[18:0];
	endproperty
	a_hit_ofs: assert property (p_hit_ofs)
		else $error("hit address offset wrong");
	// walker sees the held request address
	property p_walk_addr;
		o_walk_req |-> i_req_valid && o_walk_vaddr == i_req_addr;
	endproperty
	a_walk_addr: assert property (p_walk_addr)
		else $error("walk address differs from request");
	// exception ends an access, never nullifies
	property p_exc;
		o_addr_exc |-> o_req_done && !o_nullify;
	endproperty
	a_exc: assert property (p_exc)
		else $error("exception outside done");
	property p_null_alone;
		o_nullify |-> o_req_done && !o_req_hit && !o_addr_exc;
	endproperty
	a_null_alone: assert property (p_null_alone)
		else $error("nullify with hit or exception");
	property p_fault_null;
		o_walk_req && i_walk_fault |=> o_nullify && o_req_done;
	endproperty
	a_fault_null: assert property (p_fault_null)
		else $error("fault not nullified");
	property p_retry;
		i_buf_err && i_retryable |=> o_retry && !o_proc_damage;
	endproperty
	a_retry: assert property (p_retry)
		else $error("retryable error not retried");
	property p_damage;
		i_buf_err && !i_retryable |=> o_proc_damage && !o_retry;
	endproperty
	a_damage: assert property (p_damage)
		else $error("unretryable error not reported");
	property p_no_spurious;
		o_retry || o_proc_damage |-> $past(i_buf_err);
	endproperty
	a_no_spurious: assert property (p_no_spurious)
		else $error("error report without error");
	// pass-through: no walk, address unchanged
	property p_pass_nowalk;
		i_req_valid && i_req_kind == TLBX_KIND_NOXLT |-> !o_walk_req;
	endproperty
	a_pass_nowalk: assert property (p_pass_nowalk)
		else $error("pass-through started a walk");
	property p_pass_addr;
		o_req_done && i_req_kind == TLBX_KIND_NOXLT |-> o_real_addr == i_req_addr;
	endproperty
	a_pass_addr: assert property (p_pass_addr)
		else $error("pass-through address altered");
	c_hit: cover property (o_req_done && o_req_hit);
	c_exc: cover property (o_addr_exc);
	c_null: cover property (o_nullify);
	c_retry: cover property (o_retry);
endmodule

// ---- testbench/tlbx_walk_model.sv ----
// table-walk partner: one answer per request after a delay
// assumes result, fault and delay are set before the walk
`timescale 1ns/1ps
module tlbx_walk_model
(
	input wire logic i_ref_clk,
	input wire logic i_walk_req,
	input wire logic [31:0] i_result,
	input wire logic i_fault,
	input wire logic [1:0] i_delay,
	output logic o_walk_done,
	output logic o_walk_fault,
	output logic [31:0] o_walk_real
);
	logic answered_q; // one answer per request
	logic [2:0] wait_q; // cycles spent before answering
	initial
	begin
		o_walk_done = 1'b0;
		o_walk_fault = 1'b0;
		o_walk_real = 32'h0;
		answered_q = 1'b0;
		wait_q = 3'h0;
	end
	// idle result lines toggle so stale data never looks valid
	always @(posedge i_ref_clk)
	begin
		o_walk_done <= 1'b0;
		o_walk_fault <= 1'b0;
		o_walk_real <= ~o_walk_real;
		if (!i_walk_req)
		begin
			answered_q <= 1'b0;
			wait_q <= 3'h0;
		end
		else if (!answered_q && wait_q < {1'b0, i_delay})
			wait_q <= 3'(wait_q + 3'h1);
		else if (!answered_q)
		begin
			answered_q <= 1'b1;
			o_walk_fault <= i_fault;
			o_walk_done <= !i_fault;
			o_walk_real <= i_result;
		end
	end
endmodule

// ---- testbench/tlbx_top_tb.sv ----
// self-checking bench of the buffer with a row reference model
// assumes the design, walk model and monitor are compiled first
`timescale 1ns/1ps
module tlbx_top_tb;
	import tlbx_pkg::*;
	localparam int MISS = 20; // short miss penalty
	logic i_ref_clk, i_reset_n, i_avs_read, i_avs_write, o_avs_waitrequest;
	logic [4:0] i_avs_address;
	logic [31:0] i_avs_writedata, o_avs_readdata, i_req_addr, o_real_addr, o_walk_vaddr;
	logic i_req_valid, i_req_store, i_address_mapping_enable, o_req_done, o_req_hit;
	logic [1:0] i_req_kind, walk_dly;
	logic o_addr_exc, o_nullify, o_walk_req, i_walk_done, i_walk_fault, walk_flt;
	logic [31:0] i_walk_real, walk_res, lim_v, rd;
	logic i_buf_err, i_retryable, o_retry, o_proc_damage;
	int n_fail = 0;
	int num_checks = 0;
	// reference rows: valid, real, limit, tag, real field, lru
	logic mv[32][2], mr[32][2], mlim[32][2];
	logic [7:0] mt[32][2];
	logic [12:0] mq[32][2];
	logic [31:0] ml;
	tlbx_top #(.NUM_BLOCKS(64), .MISS_CYC(MISS)) dut_u (.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
		.i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(4'hF), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .i_req_valid(i_req_valid),
		.i_req_addr(i_req_addr), .i_req_kind(i_req_kind), .i_req_store(i_req_store),
		.i_address_mapping_enable(i_address_mapping_enable), .o_req_done(o_req_done),
		.o_req_hit(o_req_hit), .o_real_addr(o_real_addr), .o_addr_exc(o_addr_exc),
		.o_nullify(o_nullify), .o_walk_req(o_walk_req), .o_walk_vaddr(o_walk_vaddr),
		.i_walk_done(i_walk_done), .i_walk_fault(i_walk_fault), .i_walk_real(i_walk_real),
		.i_buf_err(i_buf_err), .i_retryable(i_retryable), .o_retry(o_retry),
		.o_proc_damage(o_proc_damage));
	tlbx_walk_model walk_u (.i_ref_clk(i_ref_clk), .i_walk_req(o_walk_req),
		.i_result(walk_res), .i_fault(walk_flt), .i_delay(walk_dly),
		.o_walk_done(i_walk_done), .o_walk_fault(i_walk_fault), .o_walk_real(i_walk_real));
	// 250 MHz clock
	initial
	begin
		i_ref_clk = 1'b0;
		forever #2 i_ref_clk = ~i_ref_clk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic complete_run();
		if (n_fail == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// one Avalon transfer, held until waitrequest is low
	task automatic av(input logic wr, input logic [4:0] ad, input logic [31:0] wd);
		int n = 0;
		i_avs_address <= ad;
		i_avs_writedata <= wd;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		do
		begin
			@(posedge i_ref_clk);
			n++;
		end
		while (o_avs_waitrequest !== 1'b0 && n < 1000);
		rd = o_avs_readdata;
		chk("avs_answer", 1, n < 1000);
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
		@(posedge i_ref_clk);
	endtask
	// control command, polled until not pending
	task automatic cmd(input logic [31:0] bits);
		av(1'b1, `TLBX_REG_CTRL, bits);
		rd = 32'h1;
		for (int i = 0; i < 50 && rd[0] !== 1'b0; i++)
			av(1'b0, `TLBX_REG_CTRL, 32'h0);
	endtask
	task automatic inval_all();
		mv = '{default: 1'b0};
	endtask
	task automatic key_chk(input logic [6:0] k);
		cmd(32'h8);
		av(1'b0, `TLBX_REG_KDATA, 32'h0);
		chk("key", {25'h0, k}, {25'h0, rd[6:0]});
	endtask
	// one lookup, predicted then compared
	task automatic lookup(input logic [31:0] a, input logic [1:0] k, input logic m,
		input logic st);
		logic [4:0] r;
		logic [31:0] wr, ea;
		logic flt, miss, exc, walked, cpu;
		int c, n;
		r = a[23:19];
		c = -1;
		cpu = (k == TLBX_KIND_CPU);
		for (int j = 0; j < 2; j++)
			if (mv[r][j] && mt[r][j] == a[31:24] && mr[r][j] == !m)
				c = j;
		miss = (c < 0);
		wr = $urandom;
		flt = cpu && m && miss && ($urandom_range(7) == 0);
		exc = 1'b0;
		ea = a;
		if (cpu && !flt)
		begin
			if (miss)
			begin
				c = ml[r];
				mv[r][c] = 1'b1;
				mt[r][c] = a[31:24];
				mr[r][c] = !m;
				mq[r][c] = m ? wr[31:19] : a[31:19];
				mlim[r][c] = m && (wr >= lim_v);
			end
			exc = mlim[r][c];
			if (miss || !exc)
				ml[r] = (c == 0);
			ea = {mq[r][c], a[18:0]};
		end
		walk_res <= wr;
		walk_flt <= flt;
		walk_dly <= 2'($urandom_range(3));
		i_req_addr <= a;
		i_req_kind <= k;
		i_req_store <= st;
		i_address_mapping_enable <= m;
		i_req_valid <= 1'b1;
		walked = 1'b0;
		n = 0;
		do
		begin
			@(posedge i_ref_clk);
			#1;
			n++;
			walked |= o_walk_req;
		end
		while (o_req_done !== 1'b1 && n < 2000);
		i_req_valid <= 1'b0;
		chk("done", 1, n < 2000);
		chk("walk", cpu && miss && m, walked);
		if (cpu && !flt)
			chk("exc", exc, o_addr_exc);
		if (cpu && !flt && !exc)
			chk("hit", !miss, o_req_hit);
		if (cpu && !flt && !exc)
			chk("real", ea, o_real_addr);
		if (flt)
			chk("nullify", 1, o_nullify);
		if (k == TLBX_KIND_NOXLT)
			chk("pass", a, o_real_addr);
		if (cpu && !m)
			chk("slow", miss, n > MISS);
		@(posedge i_ref_clk);
	endtask
	// random lookups on two rows, four tags: columns contend
	task automatic rand_run(input int cnt);
		logic [1:0] k;
		for (int i = 0; i < cnt; i++)
		begin
			k = ($urandom_range(5) < 4) ? 2'h0 : 2'($urandom_range(2, 1));
			lookup({8'(8'h10 + $urandom_range(3)), 5'($urandom_range(1)),
				19'($urandom)}, k, 1'($urandom), 1'($urandom));
		end
	endtask
	initial
	begin
		repeat (60000) @(posedge i_ref_clk);
		n_fail++;
		complete_run();
	end
	initial
	begin
		{i_reset_n, i_avs_read, i_avs_write, i_req_valid, i_req_store, i_buf_err} = '0;
		{i_retryable, i_address_mapping_enable, walk_flt, walk_dly} = '0;
		{i_avs_address, i_avs_writedata, i_req_addr, i_req_kind, walk_res} = '0;
		inval_all();
		ml = 32'h0;
		void'($urandom(32'h95DD2ECD));
		repeat (2) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		av(1'b0, `TLBX_REG_LIMIT, 32'h0);
		chk("limit_rst", `TLBX_LIMIT_RST, rd);
		av(1'b0, `TLBX_REG_PGSZ, 32'h0);
		chk("pgsz_rst", 32'h0, rd);
		av(1'b0, 5'h18, 32'h0);
		chk("unmapped", 32'h0, rd);
		lim_v = 32'h80000000;
		av(1'b1, `TLBX_REG_LIMIT, lim_v);
		rand_run(60);
		// key recording
		av(1'b1, `TLBX_REG_KADDR, 32'h00005800);
		av(1'b1, `TLBX_REG_KDATA, 32'h50);
		cmd(32'h4);
		for (int r = 0; r < 32; r++)
			for (int j = 0; j < 2; j++)
				if (!mr[r][j] || mq[r][j] == 13'h0000)
					mv[r][j] = 1'b0;
		key_chk(7'h50);
		lookup(32'h00005810, TLBX_KIND_CPU, 1'b0, 1'b0);
		key_chk(7'h52);
		lookup(32'h00005820, TLBX_KIND_CPU, 1'b0, 1'b1);
		key_chk(7'h53);
		cmd(32'h2);
		key_chk(7'h51);
		lookup(32'h00005830, TLBX_KIND_CHAN, 1'b0, 1'b0);
		key_chk(7'h53);
		av(1'b0, `TLBX_REG_STAT, 32'h0);
		chk("stat", 32'h1, rd);
		rand_run(40);
		cmd(32'h1);
		inval_all();
		rand_run(40);
		av(1'b1, `TLBX_REG_PGSZ, 32'h1);
		inval_all();
		av(1'b1, `TLBX_REG_PGSZ, 32'h1);
		rand_run(40);
		// buffer errors, retryable and not
		for (int e = 0; e < 2; e++)
		begin
			i_buf_err <= 1'b1;
			i_retryable <= 1'(e);
			@(posedge i_ref_clk);
			i_buf_err <= 1'b0;
			#1;
			chk("retry", e, o_retry);
			chk("damage", !e, o_proc_damage);
			@(posedge i_ref_clk);
			inval_all();
		end
		rand_run(40);
		complete_run();
	end
endmodule
bind tlbx_top tlbx_top_monitor mon_u (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
	.i_req_valid(i_req_valid), .i_req_addr(i_req_addr), .i_req_kind(i_req_kind),
	.i_walk_fault(i_walk_fault), .i_buf_err(i_buf_err), .i_retryable(i_retryable),
	.o_req_done(o_req_done), .o_req_hit(o_req_hit), .o_real_addr(o_real_addr),
	.o_addr_exc(o_addr_exc), .o_nullify(o_nullify), .o_walk_req(o_walk_req),
	.o_walk_vaddr(o_walk_vaddr), .o_retry(o_retry), .o_proc_damage(o_proc_damage));
